// >>> inc/vst_pkg.sv
// constants shared by the sync timing extractor and its bench
package vst_pkg;
   // ****************************************
   // clock and times
   // ****************************************
   localparam int CLK_NS = 10;
   localparam int HS_W_NS = 5000;
   localparam int BP_W_NS = 3700;
   localparam int BROAD_NS = 15000;
   localparam int VDEF_NS = 36000;
   localparam int HREJ_NS = 48000;
   localparam int LOSS_NS = 600000;
   localparam int HREJ_CYC = HREJ_NS / CLK_NS;
   localparam int LOSS_CYC = LOSS_NS / CLK_NS;
   localparam logic [15:0] HS_W_RST = 16'(HS_W_NS / CLK_NS);
   localparam logic [15:0] BP_W_RST = 16'(BP_W_NS / CLK_NS);
   localparam logic [15:0] BROAD_RST = 16'(BROAD_NS / CLK_NS);
   localparam logic [15:0] VDEF_RST = 16'(VDEF_NS / CLK_NS);
   localparam logic [1:0] SCAN_RST = 2'h0;
   localparam logic [7:0] MIN_AMP_RST = 8'h40;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_HS_W = 8'h04;
   localparam logic [7:0] OFF_BP_W = 8'h08;
   localparam logic [7:0] OFF_HREJ = 8'h0c;
   localparam logic [7:0] OFF_BROAD = 8'h10;
   localparam logic [7:0] OFF_VDEF = 8'h14;
   localparam logic [7:0] OFF_LOSS = 8'h18;
   localparam logic [7:0] OFF_MIN_AMP = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   // ****************************************
   // status fields and timer slots
   // ****************************************
   localparam int ST_NSD = 0;
   localparam int ST_ODD = 1;
   localparam int ST_VS = 2;
   localparam int ST_VINT = 3;
   localparam int ST_LEN_LSB = 16;
   localparam int TMR_HS = 0;
   localparam int TMR_BP = 1;
   localparam int TMR_HR = 2;
   localparam int NTMR = 3;
endpackage

// >>> inc/vst_tmr_if.sv
// start, length and busy of one programmable one-shot
`timescale 1ns/1ns
interface vst_tmr_if #(parameter int CW = 16);
   logic start;
   logic [CW-1:0] len;
   logic busy;
   modport owner (output start, output len, input busy);
   modport timer (input start, input len, output busy);
endinterface

// >>> rtl/vst_one_shot.sv
// retriggerable one-shot: busy for len cycles after start
`timescale 1ns/1ns
module vst_one_shot #(
   parameter int CW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   vst_tmr_if.timer t
);
   typedef struct packed {
      logic [CW-1:0] cnt;
   } vst_os_state_t;

   vst_os_state_t s_q;
   vst_os_state_t s_d;

   if (CW < 2)
   begin : g_bad_cw
      $error("vst_one_shot: CW must be at least 2");
   end

   always_comb
   begin
      s_d = s_q;
      if (t.start)
      begin
         // a zero length still gives one cycle so a start is never lost
         s_d.cnt = (t.len == '0) ? CW'(1) : t.len;
      end
      else if (s_q.cnt != '0)
      begin
         s_d.cnt = s_q.cnt - CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign t.busy = (s_q.cnt != '0);
endmodule

// >>> rtl/vst_sync_timing.sv
// digital timing of a video sync separator with an apb register file
// Functional notes
// R1: composite sync out copies every input pulse
// R2: vertical starts on first serration rising edge
// R3: vertical ends after first post-interval equalizing pulse
// R4: no-signal on loss or low amplitude
// R5: no-signal only after a lasting condition
// R6: back porch starts on sync trailing edge
// R7: in vertical, back porch starts on serration rise
// R8: back porch width set by programmable one-shot
// R9: odd/even low for even, high for odd
// R10: noise pulses must not flip odd/even
// R11: horizontal out only line pulses, fixed width
// R12: horizontal starts on line sync leading edge
// R13: half-line pulses removed from horizontal out
// R14: timings scale together with scan rate setting; the loss timeout loss_t is not scaled
// R15: sync outputs are active low
// R16: default vertical start without serrations
// R17: odd/even updates once per field at vertical
// R18: rejector timeout restarts after each horizontal pulse
// R19: input synchronised, durations in clock cycles
// R20: broad pulses found by counting low time
// R21: reset clears outputs, state and counters
`timescale 1ns/1ns
module vst_sync_timing
   import vst_pkg::*;
#(
   parameter int CW = 16,
   parameter int HREJ_RST = vst_pkg::HREJ_CYC,
   parameter int LOSS_RST = vst_pkg::LOSS_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic csync_in_n,
   input wire logic amp_low,
   output logic [7:0] min_amplitude_threshold,
   output logic csync_out_n,
   output logic vsync_n,
   output logic bp_n,
   output logic hsync_n,
   output logic odd_even,
   output logic nsd
);
   import vst_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [CW-1:0] low_cnt;
      logic [CW-1:0] line_cnt;
      logic [CW-1:0] line_len;
      logic [CW-1:0] loss_cnt;
      logic vint;
      logic vs_on;
      logic odd;
      logic nsd;
      logic [1:0] scan;
      logic [CW-1:0] hs_w;
      logic [CW-1:0] bp_w;
      logic [CW-1:0] hrej_t;
      logic [CW-1:0] broad_t;
      logic [CW-1:0] vdef_t;
      logic [CW-1:0] loss_t;
      logic [7:0] min_amp;
      logic [31:0] rdata;
      logic slverr;
   } vst_state_t;

   localparam vst_state_t RST = '{
      hs_w: CW'(HS_W_RST), bp_w: CW'(BP_W_RST), hrej_t: CW'(HREJ_RST),
      broad_t: CW'(BROAD_RST), vdef_t: CW'(VDEF_RST), loss_t: CW'(LOSS_RST),
      scan: SCAN_RST, min_amp: MIN_AMP_RST, s1: 1'b1, s2: 1'b1, s3: 1'b1,
      default: '0};

   vst_state_t s_q;
   vst_state_t s_d;

   if (CW < 16 || CW > 32 || (CW < 31 && (HREJ_RST >= 2**CW || LOSS_RST >= 2**CW)))
   begin : g_bad_par
      $error("vst_sync_timing: counts do not fit in CW bits");
   end

   // ****************************************
   // decoding
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic fall;
   logic rise;
   logic broad;
   logic vs_ser;
   logic vs_def;
   logic vs_start;
   logic vs_end;
   logic hs_start;
   logic mid_line;
   logic wr;
   logic rd_setup;
   logic [CW-1:0] quarter;
   logic [NTMR-1:0] t_start;
   logic [NTMR-1:0] t_busy;
   logic [CW-1:0] t_len [NTMR];

   // R19 synchronised edges
   assign fall = s_q.s3 & ~s_q.s2;
   assign rise = ~s_q.s3 & s_q.s2;
   // R14 thresholds scale with the scan setting
   assign broad = s_q.low_cnt >= (s_q.broad_t >> s_q.scan);
   // R2 first serration rise ends a broad pulse
   assign vs_ser = rise & broad & s_q.vint & ~s_q.vs_on;
   // R16 default start after a long unbroken low
   assign vs_def = ~s_q.s2 & ~s_q.vs_on & (s_q.low_cnt == (s_q.vdef_t >> s_q.scan));
   assign vs_start = vs_ser | vs_def;
   // R3 first short pulse after the interval ends vertical
   assign vs_end = s_q.vs_on & rise & ~broad;
   // R13 leading edges inside the rejector timeout are ignored
   assign hs_start = fall & ~t_busy[TMR_HR];
   assign quarter = s_q.line_len >> 2;
   assign mid_line = (s_q.line_cnt > quarter) && (s_q.line_cnt < (s_q.line_len - quarter));
   assign wr = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_d = s_q;
      // R19 two-stage synchroniser, third stage for edges
      s_d.s1 = csync_in_n;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // R20 low time counted, restarted on each edge
      if (fall | rise)
      begin
         s_d.low_cnt = '0;
      end
      else if (~s_q.s2 && s_q.low_cnt != '1)
      begin
         s_d.low_cnt = s_q.low_cnt + CW'(1);
      end
      if (~s_q.s2 & broad)
      begin
         s_d.vint = 1'b1;
      end
      else if (vs_end)
      begin
         s_d.vint = 1'b0;
      end
      // R2 R3 vertical pulse state
      if (vs_start)
      begin
         s_d.vs_on = 1'b1;
      end
      else if (vs_end)
      begin
         s_d.vs_on = 1'b0;
      end
      // R17 R9 field parity from line phase at vertical start
      if (vs_start)
      begin
         s_d.odd = mid_line;
      end
      // R10 only gated line pulses time the line, so noise cannot move it
      if (hs_start)
      begin
         s_d.line_cnt = '0;
         s_d.line_len = s_q.line_cnt;
      end
      else if (s_q.line_cnt != '1)
      begin
         s_d.line_cnt = s_q.line_cnt + CW'(1);
      end
      // R4 loss or low amplitude keeps counting
      if (fall & ~amp_low)
      begin
         s_d.loss_cnt = '0;
      end
      else if (s_q.loss_cnt != '1)
      begin
         s_d.loss_cnt = s_q.loss_cnt + CW'(1);
      end
      // R5 flag only once the condition has lasted
      s_d.nsd = (s_q.loss_cnt >= s_q.loss_t);
      // apb write takes effect in the access cycle
      if (wr)
      begin
         if (hit(paddr, OFF_CTRL))
            s_d.scan = pwdata[1:0];
         if (hit(paddr, OFF_HS_W))
            s_d.hs_w = pwdata[CW-1:0];
         if (hit(paddr, OFF_BP_W))
            s_d.bp_w = pwdata[CW-1:0];
         if (hit(paddr, OFF_HREJ))
            s_d.hrej_t = pwdata[CW-1:0];
         if (hit(paddr, OFF_BROAD))
            s_d.broad_t = pwdata[CW-1:0];
         if (hit(paddr, OFF_VDEF))
            s_d.vdef_t = pwdata[CW-1:0];
         if (hit(paddr, OFF_LOSS))
            s_d.loss_t = pwdata[CW-1:0];
         if (hit(paddr, OFF_MIN_AMP))
            s_d.min_amp = pwdata[7:0];
      end
      // read data and error are registered at the setup edge
      if (psel & ~penable)
      begin
         s_d.rdata = '0;
         s_d.slverr = 1'b0;
         if (hit(paddr, OFF_CTRL))
            s_d.rdata[1:0] = s_q.scan;
         else if (hit(paddr, OFF_HS_W))
            s_d.rdata[CW-1:0] = s_q.hs_w;
         else if (hit(paddr, OFF_BP_W))
            s_d.rdata[CW-1:0] = s_q.bp_w;
         else if (hit(paddr, OFF_HREJ))
            s_d.rdata[CW-1:0] = s_q.hrej_t;
         else if (hit(paddr, OFF_BROAD))
            s_d.rdata[CW-1:0] = s_q.broad_t;
         else if (hit(paddr, OFF_VDEF))
            s_d.rdata[CW-1:0] = s_q.vdef_t;
         else if (hit(paddr, OFF_LOSS))
            s_d.rdata[CW-1:0] = s_q.loss_t;
         else if (hit(paddr, OFF_MIN_AMP))
            s_d.rdata[7:0] = s_q.min_amp;
         else if (hit(paddr, OFF_STATUS) & rd_setup)
         begin
            s_d.rdata[ST_NSD] = s_q.nsd;
            s_d.rdata[ST_ODD] = s_q.odd;
            s_d.rdata[ST_VS] = s_q.vs_on;
            s_d.rdata[ST_VINT] = s_q.vint;
            s_d.rdata[ST_LEN_LSB +: 16] = s_q.line_len[15:0];
         end
         else
            // status is read only, so a write there errors too
            s_d.slverr = 1'b1;
      end
   end

   // R21 async reset to constants only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // one-shots
   // ****************************************
   // R12 R18 line pulse and rejector timeout start together
   assign t_start[TMR_HS] = hs_start;
   assign t_start[TMR_HR] = hs_start;
   // R6 R7 every trailing edge, serrations included
   assign t_start[TMR_BP] = rise;
   // R8 R11 R14 widths from registers, scaled by scan
   assign t_len[TMR_HS] = s_q.hs_w >> s_q.scan;
   assign t_len[TMR_BP] = s_q.bp_w >> s_q.scan;
   assign t_len[TMR_HR] = s_q.hrej_t >> s_q.scan;

   vst_tmr_if #(.CW(CW)) tif [NTMR] ();

   for (genvar i = 0; i < NTMR; i++)
   begin : g_tmr
      assign tif[i].start = t_start[i];
      assign tif[i].len = t_len[i];
      assign t_busy[i] = tif[i].busy;
      vst_one_shot #(.CW(CW)) u_os (
         .pclk(pclk),
         .presetn(presetn),
         .t(tif[i])
      );
   end

   // ****************************************
   // outputs
   // ****************************************
   // R1 R15 active-low copy, three cycles late
   assign csync_out_n = s_q.s3;
   assign vsync_n = ~s_q.vs_on;
   assign bp_n = ~t_busy[TMR_BP];
   assign hsync_n = ~t_busy[TMR_HS];
   assign odd_even = s_q.odd;
   assign nsd = s_q.nsd;
   assign min_amplitude_threshold = s_q.min_amp;
   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = s_q.slverr & psel & penable;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_cs_copy: assert property ($past(presetn, 4) |-> csync_out_n == $past(csync_in_n, 3)) // R1
      else $error("composite sync is not a delayed copy");
   chk_vs_begin: assert property (vs_start |=> !vsync_n ##0 $changed(vsync_n)) // R2
      else $error("vertical did not start");
   chk_vs_finish: assert property (vs_end |=> vsync_n) // R3
      else $error("vertical did not end on short pulse");
   chk_nsd_raise: assert property ((s_q.loss_cnt >= s_q.loss_t) |=> nsd) // R4
      else $error("no-signal not raised");
   chk_nsd_clear: assert property ((fall && !amp_low && s_q.loss_t != '0) |=> ##1 !nsd) // R5
      else $error("no-signal stayed after good sync");
   chk_bp_start: assert property (rise |=> !bp_n) // R6
      else $error("back porch did not start");
   chk_hs_start: assert property (hs_start |=> (!hsync_n && t_busy[TMR_HR])) // R18
      else $error("horizontal or rejector did not start");
   chk_hs_reject: assert property ((fall && t_busy[TMR_HR] && hsync_n) |=> hsync_n) // R13
      else $error("half-line pulse reached horizontal output");
   chk_oe_hold: assert property (!vs_start |=> $stable(odd_even)) // R17
      else $error("odd/even changed outside vertical start");

   cov_vs_serr: cover property (vs_ser);
   cov_vs_dflt: cover property (vs_def);
   cov_nsd_up: cover property ($rose(nsd));
   cov_oe_flip: cover property ($changed(odd_even));
endmodule

// >>> bench/vst_slicer_model.sv
// behavioural analog slicer: sliced sync for lines, fields and loss
`timescale 1ns/1ns
module vst_slicer_model (
   input wire logic pclk,
   input wire logic [1:0] mode,
   input wire logic [3:0] pre_eq,
   output logic csync_in_n,
   output int fields
);
   // one low pulse and its rest; line is 100 cycles, half line 50
   task automatic pls(input int lo, input int per);
      csync_in_n <= 1'b0;
      repeat (lo) @(posedge pclk);
      csync_in_n <= 1'b1;
      repeat (per - lo) @(posedge pclk);
   endtask
   initial
   begin
      csync_in_n = 1'b1;
      fields = 0;
      forever
      begin
         // no signal: sliced sync rests at its idle level
         if (mode == 2'h0)
            @(posedge pclk);
         else if (mode == 2'h1)
            pls(8, 100);
         else
         begin
            repeat (pre_eq) pls(4, 50);
            // mode 3 has no serrations, one long broad pulse instead
            if (mode == 2'h2)
               repeat (6) pls(30, 50);
            else
               // a short rest keeps the trailing edge apart from the first equalizer
               pls(296, 300);
            repeat (6) pls(4, 50);
            fields++;
         end
      end
   end
endmodule

// >>> bench/tb_video_sync_timing_extractor.sv
// self-checking bench for the video sync timing extractor
`timescale 1ns/1ns
module tb_video_sync_timing_extractor;
   import vst_pkg::*;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] r; logic e;} vst_row_t;
   localparam int HREJ_T = 60;
   localparam int LOSS_T = 200;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic amp_low = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, csync_in_n, csync_out_n, vsync_n, bp_n, hsync_n, odd_even, nsd, er;
   logic [7:0] min_amplitude_threshold;
   logic [1:0] mode = 2'h0;
   logic [3:0] pre_eq = 4'h6;
   logic [2:0] h = 3'h7;
   logic pb = 1'b1;
   logic pc = 1'b1;
   logic ph = 1'b1;
   logic loe;
   int fields, since = 0, error_cnt = 0, total_checks = 0;
   int hw = 0, bw = 0, vw = 0, hg = 0, hgmin = 1000, lhw, lbw, lvw;
   vst_row_t rows [19] = '{
      '{OFF_HREJ, 0, 0, 32'(HREJ_T), 0}, '{OFF_LOSS, 0, 0, 32'(LOSS_T), 0},
      '{OFF_CTRL, 0, 0, 0, 0}, '{OFF_HS_W, 0, 0, 32'(HS_W_RST), 0},
      '{OFF_BP_W, 0, 0, 32'(BP_W_RST), 0}, '{OFF_BROAD, 0, 0, 32'(BROAD_RST), 0},
      '{OFF_VDEF, 0, 0, 32'(VDEF_RST), 0}, '{OFF_MIN_AMP, 0, 0, 32'(MIN_AMP_RST), 0},
      '{OFF_STATUS, 0, 0, 0, 0}, '{8'h24, 0, 0, 0, 1}, '{8'h02, 0, 0, 0, 1},
      '{OFF_STATUS, 1, 5, 0, 1}, '{OFF_HS_W, 1, 10, 0, 0}, '{OFF_BP_W, 1, 32'hffff0008, 0, 0},
      '{OFF_BROAD, 1, 20, 0, 0}, '{OFF_VDEF, 1, 100, 0, 0}, '{OFF_MIN_AMP, 1, 32'h55, 0, 0},
      '{OFF_BP_W, 0, 0, 8, 0}, '{OFF_MIN_AMP, 0, 0, 32'h55, 0}};
   always #5 pclk = ~pclk;
   vst_sync_timing #(.HREJ_RST(HREJ_T), .LOSS_RST(LOSS_T)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .csync_in_n(csync_in_n),
      .amp_low(amp_low), .min_amplitude_threshold(min_amplitude_threshold),
      .csync_out_n(csync_out_n), .vsync_n(vsync_n), .bp_n(bp_n), .hsync_n(hsync_n),
      .odd_even(odd_even), .nsd(nsd));
   vst_slicer_model src_u (.pclk(pclk), .mode(mode), .pre_eq(pre_eq),
      .csync_in_n(csync_in_n), .fields(fields));
   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; answer sampled at the edge where pready is seen
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      logic r;
      r = 1'b0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // answer taken at the rising edge where pready is seen; a hang ends in the watchdog
      while (r !== 1'b1)
      begin
         @(posedge pclk);
         rd = prdata;
         er = pslverr;
         r = pready;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_field();
      int f;
      f = fields;
      while (fields == f)
         @(posedge pclk);
   endtask
   // ****************************************
   // output monitor, sampled mid-cycle
   // ****************************************
   always @(negedge pclk)
   begin
      since = presetn ? since + 1 : 0;
      // sync chain restarts idle after reset, so history is trusted later
      if (since > 3)
      begin
         cmp("csync_out_n", 32'(h[2]), 32'(csync_out_n));
         if (!bp_n && pb)
            cmp("bp_start", 32'h1, 32'(csync_out_n & ~pc));
         if (!hsync_n && ph)
            cmp("hs_start", 32'h1, 32'(~csync_out_n & pc));
      end
      h = {h[1:0], csync_in_n};
      pb = bp_n;
      pc = csync_out_n;
      ph = hsync_n;
      hg++;
      if (!hsync_n && hw == 0)
      begin
         hgmin = (hg < hgmin) ? hg : hgmin;
         hg = 0;
      end
      if (!hsync_n)
         hw++;
      else if (hw > 0)
      begin
         lhw = hw;
         hw = 0;
      end
      if (!bp_n)
         bw++;
      else if (bw > 0)
      begin
         lbw = bw;
         bw = 0;
      end
      if (!vsync_n)
         vw++;
      else if (vw > 0)
      begin
         lvw = vw;
         loe = odd_even;
         vw = 0;
      end
   end
   initial
   begin
      cyc(40000);
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      cyc(10);
      presetn <= 1'b1;
      cyc(2);
      foreach (rows[i])
      begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         cmp("pslverr", 32'(rows[i].e), 32'(er));
         if (!rows[i].w)
            cmp("prdata", rows[i].r, rd);
      end
      cmp("min_amp", 32'h55, 32'(min_amplitude_threshold));
      mode <= 2'h1;
      cyc(500);
      cmp("hs_width", 32'd10, lhw);
      cmp("bp_width", 32'd8, lbw);
      hgmin = 1000;
      mode <= 2'h2;
      wait_field();
      cmp("hs_gap", 32'd100, hgmin);
      cmp("vs_width", 32'd274, lvw);
      cmp("odd", 32'h1, 32'(loe));
      // odd count of equalizers moves the vertical to the line start
      pre_eq <= 4'h7;
      wait_field();
      wait_field();
      cmp("even", 32'h0, 32'(loe));
      mode <= 2'h3;
      wait_field();
      wait_field();
      cmp("vs_default", 32'h1, 32'(lvw > 195 && lvw < 215));
      mode <= 2'h1;
      wait_field();
      apb(OFF_CTRL, 1'b1, 32'h1);
      cyc(500);
      cmp("hs_scaled", 32'd5, lhw);
      cmp("bp_scaled", 32'd4, lbw);
      apb(OFF_CTRL, 1'b1, 32'h0);
      mode <= 2'h0;
      cyc(150);
      cmp("nsd_early", 32'h0, 32'(nsd));
      cyc(250);
      cmp("nsd_loss", 32'h1, 32'(nsd));
      mode <= 2'h1;
      cyc(300);
      cmp("nsd_back", 32'h0, 32'(nsd));
      // loss time runs from the last good edge, up to a line before amp_low rises
      amp_low <= 1'b1;
      cyc(50);
      cmp("nsd_amp_early", 32'h0, 32'(nsd));
      cyc(100);
      cmp("nsd_amp", 32'h1, 32'(nsd));
      presetn <= 1'b0;
      @(negedge pclk);
      cmp("reset_out", 32'h3c, 32'({csync_out_n, vsync_n, bp_n, hsync_n, odd_even, nsd}));
      cyc(3);
      presetn <= 1'b1;
      cyc(20);
      give_verdict();
   end
endmodule
